// File: pmr_defs.svh
// Register offsets, field positions and reset values of the power bank
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH
`define PMR_ADDR_W        6
`define PMR_DATA_W        16
`define PMR_OFF_RESET_ID  6'h00
`define PMR_OFF_REF_DIV   6'h04
`define PMR_OFF_BIAS      6'h05
`define PMR_OFF_POWER     6'h0B
`define PMR_OFF_CLOCKS    6'h0E
`define PMR_OFF_FREQ_LOOP 6'h10
`define PMR_OFF_RANGE     6'h20
`define PMR_OFF_WSEQ      6'h26
`define PMR_OFF_EQ        6'h2A
`define PMR_OFF_CLK_DIV   6'h0C
`define PMR_IDENTITY      16'h5A3C  // Identity word; value arbitrary
`define PMR_RST_REF_DIV   16'h0001
`define PMR_RST_BIAS      16'h0068
`define PMR_RST_POWER     16'h0180
`define PMR_RST_CLOCKS    16'h0000
`define PMR_RST_CLK_DIV   16'h0000
`define PMR_RST_ZERO      16'h0000
`define PMR_MASK_REF_DIV  16'h002F
`define PMR_MASK_BIAS     16'h007F
`define PMR_MASK_POWER    16'h0197
`define PMR_MASK_CLOCKS   16'h2027
`define PMR_MASK_CLK_DIV  16'h1DC0
`define PMR_MASK_LOOP     16'h000D
`define PMR_MASK_BIT15    16'h8000
`define PMR_MASK_BIT0     16'h0001
`define PMR_BIT_REF_LO    1
`define PMR_BIT_REF_HI    2
`define PMR_BIT_NORMAL_BIAS_ENABLE  1
`define PMR_BIT_TSHUT     8
`define PMR_BIT_TSENSE    7
`define PMR_BIT_OVERTEMP  6
`define PMR_BIT_LINE_OUT  4
`define PMR_BIT_SPK_GAIN  2
`define PMR_BIT_SPK_OUT   1
`define PMR_BIT_CONV      0
`define PMR_BIT_CLK_OUT   5
`define PMR_BIT_TIMEOUT   2
`define PMR_BIT_DSP_CLK   1
`define PMR_BIT_SYS_CLK   0
`define PMR_BIT_LOOP_ENA  0
`define PMR_BIT_TOP_ENA   15
`define PMR_DIV_LO        10
`define PMR_DIV_HI        12
`endif

// File: pmr_pkg.sv
// Types shared by the power enable register bank
package pmr_pkg;
  // Reference divider codes
  typedef enum logic [1:0] {
    PMR_REF_OFF    = 2'h0,
    PMR_REF_NORMAL = 2'h1,
    PMR_REF_STBY   = 2'h2,
    PMR_REF_FAST   = 2'h3
  } pmr_ref_sel_t;
endpackage : pmr_pkg

// File: pmr_sync.sv
// Two flip-flop synchroniser for a level from another domain
`timescale 1ns/100ps
`default_nettype none
module pmr_sync (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic reset_in,
  // Level in and out
  input  wire logic level_in,
  output var  logic level_out
);
  logic meta_q;  // First stage, read only by the second

  // Two stage capture
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta_q    <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_q    <= level_in;
      level_out <= meta_q;
    end
  end
endmodule : pmr_sync
`default_nettype wire

// File: pmr_bank.sv
// Power enable, clock enable and software reset register bank
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.svh"
module pmr_bank
  import pmr_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  // Software register port
  input  wire logic [`PMR_ADDR_W-1:0] addr_in,
  input  wire logic [`PMR_DATA_W-1:0] wdata_in,
  input  wire logic                   write_in,
  input  wire logic                   read_in,
  output var  logic [`PMR_DATA_W-1:0] rdata_out,
  // Sequencer write port, same timing as software writes
  input  wire logic [`PMR_ADDR_W-1:0] seq_addr_in,
  input  wire logic [`PMR_DATA_W-1:0] seq_wdata_in,
  input  wire logic                   seq_write_in,
  // Over-temperature flag from the analogue sensor
  input  wire logic                   over_temp_in,
  // Analogue and clock enables
  output var  pmr_ref_sel_t           mid_rail_divider_select_out,
  output var  logic                   normal_bias_enable_out,
  output var  logic                   temperature_sensor_enable_out,
  output var  logic                   line_output_enable_out,
  output var  logic                   speaker_gain_stage_enable_out,
  output var  logic                   speaker_output_enable_out,
  output var  logic                   converter_enable_out,
  output var  logic                   clock_output_enable_out,
  output var  logic [2:0]             clock_output_divider_out,
  output var  logic                   timeout_clock_enable_out,
  output var  logic                   processing_clock_enable_out,
  output var  logic                   system_clock_enable_out,
  output var  logic                   frequency_loop_enable_out,
  output var  logic                   range_controller_enable_out,
  output var  logic                   write_sequencer_enable_out,
  output var  logic                   equalizer_enable_out
);
  logic [`PMR_DATA_W-1:0] ref_div_q;    // Reference divider control
  logic [`PMR_DATA_W-1:0] bias_q;       // Bias control
  logic [`PMR_DATA_W-1:0] power_q;      // Power enables
  logic [`PMR_DATA_W-1:0] clk_div_q;    // Clock output divider
  logic [`PMR_DATA_W-1:0] clocks_q;     // Clock enables
  logic [`PMR_DATA_W-1:0] loop_q;       // Frequency loop control
  logic [`PMR_DATA_W-1:0] range_q;      // Range controller control
  logic [`PMR_DATA_W-1:0] wseq_q;       // Write sequencer control
  logic [`PMR_DATA_W-1:0] eq_q;         // Equalizer control
  logic                   over_temp_s;  // Synchronised over-temperature
  logic                   shutdown_q;   // Latched thermal shutdown
  logic                   wr_en;        // Merged write strobe
  logic [`PMR_ADDR_W-1:0] wr_addr;      // Merged write address
  logic [`PMR_DATA_W-1:0] wr_data;      // Merged write data
  logic                   soft_reset;   // Write to address zero
  logic                   shut_now;     // Shutdown condition
  logic [`PMR_DATA_W-1:0] rd_d;         // Read mux

  // Over-temperature comes from the analogue side
  pmr_sync u_temp_sync (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .level_in  (over_temp_in),
    .level_out (over_temp_s)
  );

  // Merge ports: software wins when both write in one cycle
  // sequencer write path
  always_comb begin
    wr_en   = write_in | seq_write_in;
    wr_addr = write_in ? addr_in : seq_addr_in;
    wr_data = write_in ? wdata_in : seq_wdata_in;
  end

  assign soft_reset = wr_en && (wr_addr == `PMR_OFF_RESET_ID);

  assign shut_now = power_q[`PMR_BIT_TSHUT] & power_q[`PMR_BIT_TSENSE]
                    & over_temp_s;

  // Analogue reference and bias registers
  // divider select reset
  always_ff @(posedge clock_in) begin
    if (reset_in || soft_reset) begin
      ref_div_q <= `PMR_RST_REF_DIV;
      bias_q    <= `PMR_RST_BIAS;
    end else if (wr_en) begin
      if (wr_addr == `PMR_OFF_REF_DIV) begin
        ref_div_q <= wr_data & `PMR_MASK_REF_DIV;
      end
      if (wr_addr == `PMR_OFF_BIAS) begin
        bias_q <= wr_data & `PMR_MASK_BIAS;
      end
    end
  end

  // Power enables register
  // output and converter bits
  always_ff @(posedge clock_in) begin
    if (reset_in || soft_reset) begin
      power_q <= `PMR_RST_POWER;
    end else if (wr_en && wr_addr == `PMR_OFF_POWER) begin
      power_q <= wr_data & `PMR_MASK_POWER;
    end
  end

  // Thermal shutdown latch, cleared when the flag falls, by disabling shutdown or by reset
  // latch on overtemperature
  always_ff @(posedge clock_in) begin
    if (reset_in || soft_reset) begin
      shutdown_q <= 1'b0;
    end else if (shut_now) begin
      shutdown_q <= 1'b1;
    end else if (!over_temp_s || !power_q[`PMR_BIT_TSHUT]) begin
      shutdown_q <= 1'b0;
    end
  end

  // Clock registers
  // timeout clock bit
  always_ff @(posedge clock_in) begin
    if (reset_in || soft_reset) begin
      clocks_q  <= `PMR_RST_CLOCKS;
      clk_div_q <= `PMR_RST_CLK_DIV;
    end else if (wr_en) begin
      if (wr_addr == `PMR_OFF_CLOCKS) begin
        clocks_q <= wr_data & `PMR_MASK_CLOCKS;
      end
      if (wr_addr == `PMR_OFF_CLK_DIV) begin
        clk_div_q <= wr_data & `PMR_MASK_CLK_DIV;
      end
    end
  end

  // Loop, range, sequencer and equalizer controls
  // single-bit enables
  always_ff @(posedge clock_in) begin
    if (reset_in || soft_reset) begin
      loop_q  <= `PMR_RST_ZERO;
      range_q <= `PMR_RST_ZERO;
      wseq_q  <= `PMR_RST_ZERO;
      eq_q    <= `PMR_RST_ZERO;
    end else if (wr_en) begin
      if (wr_addr == `PMR_OFF_FREQ_LOOP) begin
        loop_q <= wr_data & `PMR_MASK_LOOP;
      end
      if (wr_addr == `PMR_OFF_RANGE) begin
        range_q <= wr_data & `PMR_MASK_BIT15;
      end
      if (wr_addr == `PMR_OFF_WSEQ) begin
        wseq_q <= wr_data & `PMR_MASK_BIT15;
      end
      if (wr_addr == `PMR_OFF_EQ) begin
        eq_q <= wr_data & `PMR_MASK_BIT0;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (addr_in)
      `PMR_OFF_RESET_ID:  rd_d = `PMR_IDENTITY;
      `PMR_OFF_REF_DIV:   rd_d = ref_div_q;
      `PMR_OFF_BIAS:      rd_d = bias_q;
      `PMR_OFF_POWER: begin
        rd_d = power_q;
        rd_d[`PMR_BIT_OVERTEMP] = shutdown_q;
      end
      `PMR_OFF_CLK_DIV:   rd_d = clk_div_q;
      `PMR_OFF_CLOCKS:    rd_d = clocks_q;
      `PMR_OFF_FREQ_LOOP: rd_d = loop_q;
      `PMR_OFF_RANGE:     rd_d = range_q;
      `PMR_OFF_WSEQ:      rd_d = wseq_q;
      `PMR_OFF_EQ:        rd_d = eq_q;
      default:            rd_d = `PMR_RST_ZERO;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_out <= `PMR_RST_ZERO;
    end else if (read_in) begin
      rdata_out <= rd_d;
    end else begin
      rdata_out <= `PMR_RST_ZERO;
    end
  end

  // Registered enable outputs
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mid_rail_divider_select_out   <= PMR_REF_OFF;
      normal_bias_enable_out        <= 1'b0;
      temperature_sensor_enable_out <= 1'b0;
      line_output_enable_out        <= 1'b0;
      speaker_gain_stage_enable_out <= 1'b0;
      speaker_output_enable_out     <= 1'b0;
      converter_enable_out          <= 1'b0;
      clock_output_enable_out       <= 1'b0;
      clock_output_divider_out      <= 3'h0;
      timeout_clock_enable_out      <= 1'b0;
      processing_clock_enable_out   <= 1'b0;
      system_clock_enable_out       <= 1'b0;
      frequency_loop_enable_out     <= 1'b0;
      range_controller_enable_out   <= 1'b0;
      write_sequencer_enable_out    <= 1'b0;
      equalizer_enable_out          <= 1'b0;
    end else begin
      mid_rail_divider_select_out <= pmr_ref_sel_t'(
        ref_div_q[`PMR_BIT_REF_HI:`PMR_BIT_REF_LO]);
      normal_bias_enable_out        <= bias_q[`PMR_BIT_NORMAL_BIAS_ENABLE];
      temperature_sensor_enable_out <= power_q[`PMR_BIT_TSENSE];
      line_output_enable_out <= power_q[`PMR_BIT_LINE_OUT] & ~shutdown_q;
      speaker_gain_stage_enable_out <=
        power_q[`PMR_BIT_SPK_GAIN] & ~shutdown_q;
      speaker_output_enable_out <= power_q[`PMR_BIT_SPK_OUT] & ~shutdown_q;
      converter_enable_out      <= power_q[`PMR_BIT_CONV];
      clock_output_enable_out   <= clocks_q[`PMR_BIT_CLK_OUT];
      clock_output_divider_out  <= clk_div_q[`PMR_DIV_HI:`PMR_DIV_LO];
      timeout_clock_enable_out  <= clocks_q[`PMR_BIT_TIMEOUT];
      processing_clock_enable_out <= clocks_q[`PMR_BIT_DSP_CLK];
      system_clock_enable_out     <= clocks_q[`PMR_BIT_SYS_CLK];
      frequency_loop_enable_out   <= loop_q[`PMR_BIT_LOOP_ENA];
      range_controller_enable_out <= range_q[`PMR_BIT_TOP_ENA];
      write_sequencer_enable_out  <= wseq_q[`PMR_BIT_TOP_ENA];
      equalizer_enable_out        <= eq_q[`PMR_BIT_CONV];
    end
  end

  // Soft reset restores power enables in the next cycle
  chk_soft_reset_power: assert property (@(posedge clock_in)
    disable iff (reset_in) soft_reset |=> power_q == `PMR_RST_POWER)
    else $error("power register not restored by soft reset");

  // Identity returned one cycle after a read of zero
  chk_identity_read: assert property (@(posedge clock_in)
    disable iff (reset_in)
    read_in && addr_in == `PMR_OFF_RESET_ID |=> rdata_out == `PMR_IDENTITY)
    else $error("identity word wrong");

  // Speaker off two cycles after shutdown condition
  chk_shutdown_outputs: assert property (@(posedge clock_in)
    disable iff (reset_in)
    shut_now && !soft_reset |=> ##1 !speaker_output_enable_out
      && !line_output_enable_out)
    else $error("outputs not disabled on overtemperature");

  // No shutdown without sensor
  chk_sensor_gates: assert property (@(posedge clock_in)
    disable iff (reset_in)
    !power_q[`PMR_BIT_TSENSE] && !shutdown_q |=> !shutdown_q)
    else $error("shutdown without sensor enabled");

  // Divider select follows register
  chk_ref_select: assert property (@(posedge clock_in)
    disable iff (reset_in)
    1'b1 |=> mid_rail_divider_select_out ==
      $past(ref_div_q[`PMR_BIT_REF_HI:`PMR_BIT_REF_LO]))
    else $error("divider select mismatch");

  // Bias enable write reaches output in two cycles
  chk_bias_enable: assert property (@(posedge clock_in)
    disable iff (reset_in)
    wr_en && wr_addr == `PMR_OFF_BIAS |=> ##1
      normal_bias_enable_out == $past(wr_data[`PMR_BIT_NORMAL_BIAS_ENABLE], 2))
    else $error("bias enable not applied");

  // Clock output enable written reaches output
  chk_clock_output: assert property (@(posedge clock_in)
    disable iff (reset_in)
    wr_en && wr_addr == `PMR_OFF_CLOCKS |=> ##1
      clock_output_enable_out == $past(wr_data[`PMR_BIT_CLK_OUT], 2))
    else $error("clock output enable not applied");

  // Timeout clock enable follows its bit
  chk_timeout_clock: assert property (@(posedge clock_in)
    disable iff (reset_in)
    1'b1 |=> timeout_clock_enable_out == $past(clocks_q[`PMR_BIT_TIMEOUT]))
    else $error("timeout clock enable mismatch");
endmodule : pmr_bank
`default_nettype wire

// File: pmr_bank_tb.sv
// Self-checking testbench for the power enable register bank
`timescale 1ns/100ps
`default_nettype none
`include "pmr_defs.svh"
module pmr_bank_tb;
  import pmr_pkg::*;
  // Clock, reset and register port
  logic        clock_in, reset_in, write_in, read_in;
  logic [5:0]  addr_in, seq_addr_in;
  logic [15:0] wdata_in, seq_wdata_in, rdata_out;
  logic        seq_write_in, over_temp_in;
  // Enable outputs
  pmr_ref_sel_t mid_rail_divider_select_out;
  logic normal_bias_enable_out, temperature_sensor_enable_out;
  logic line_output_enable_out, speaker_gain_stage_enable_out;
  logic speaker_output_enable_out, converter_enable_out;
  logic clock_output_enable_out, timeout_clock_enable_out;
  logic [2:0] clock_output_divider_out;
  logic processing_clock_enable_out, system_clock_enable_out;
  logic frequency_loop_enable_out, range_controller_enable_out;
  logic write_sequencer_enable_out, equalizer_enable_out;
  // Bench state
  int          num_errors = 0;
  int          samples_checked = 0;
  int          i;
  logic [31:0] rnd;
  logic        rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  // Register table: offsets, defaults and writable bits
  logic [5:0]  offs [10] = '{`PMR_OFF_RESET_ID, `PMR_OFF_REF_DIV,
    `PMR_OFF_BIAS, `PMR_OFF_POWER, `PMR_OFF_CLK_DIV, `PMR_OFF_CLOCKS,
    `PMR_OFF_FREQ_LOOP, `PMR_OFF_RANGE, `PMR_OFF_WSEQ, `PMR_OFF_EQ};
  logic [15:0] dflt [10] = '{`PMR_IDENTITY, `PMR_RST_REF_DIV,
    `PMR_RST_BIAS, `PMR_RST_POWER, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] msk [10] = '{`PMR_IDENTITY, `PMR_MASK_REF_DIV,
    `PMR_MASK_BIAS, `PMR_MASK_POWER, `PMR_MASK_CLK_DIV, `PMR_MASK_CLOCKS,
    `PMR_MASK_LOOP, `PMR_MASK_BIT15, `PMR_MASK_BIT15, `PMR_MASK_BIT0};

  // Device under test
  pmr_bank pmr_bank_inst (
    .clock_in, .reset_in, .addr_in, .wdata_in, .write_in, .read_in,
    .rdata_out, .seq_addr_in, .seq_wdata_in, .seq_write_in, .over_temp_in,
    .mid_rail_divider_select_out, .normal_bias_enable_out,
    .temperature_sensor_enable_out, .line_output_enable_out,
    .speaker_gain_stage_enable_out, .speaker_output_enable_out,
    .converter_enable_out, .clock_output_enable_out,
    .clock_output_divider_out, .timeout_clock_enable_out,
    .processing_clock_enable_out, .system_clock_enable_out,
    .frequency_loop_enable_out, .range_controller_enable_out,
    .write_sequencer_enable_out, .equalizer_enable_out
  );

  // 200 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  // Compare and count one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Print the verdict and stop
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // One bus cycle; e is the expected read data or the sequencer data
  task automatic op(input logic w, input logic r, input logic s,
                    input logic [5:0] a, input logic [15:0] d,
                    input logic [15:0] e);
    @(posedge clock_in);
    write_in     <= w;
    read_in      <= r;
    seq_write_in <= s;
    addr_in      <= a;
    seq_addr_in  <= a;
    wdata_in     <= d;
    seq_wdata_in <= e;
    if (r) begin
      exp_q.push_back(e);
    end
  endtask : op

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, 1'b0, a, d, 16'h0);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    op(1'b0, 1'b1, 1'b0, a, 16'h0, e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b0, 6'h0, 16'h0, 16'h0);
  endtask : idle

  // All enable outputs packed, select on top
  function automatic logic [31:0] outs();
    return {13'h0, mid_rail_divider_select_out, normal_bias_enable_out,
      temperature_sensor_enable_out, line_output_enable_out,
      speaker_gain_stage_enable_out, speaker_output_enable_out,
      converter_enable_out, clock_output_enable_out,
      clock_output_divider_out, timeout_clock_enable_out,
      processing_clock_enable_out, system_clock_enable_out,
      frequency_loop_enable_out, range_controller_enable_out,
      write_sequencer_enable_out, equalizer_enable_out};
  endfunction : outs

  // Output stage enables and converter, sampled once settled
  task automatic chk_pwr(input logic [3:0] e);
    #1;
    chk({28'h0, line_output_enable_out, speaker_gain_stage_enable_out,
         speaker_output_enable_out, converter_enable_out}, {28'h0, e});
  endtask : chk_pwr

  // Every register at its default, unmapped reads give zero
  task automatic defaults_check();
    for (i = 0; i < 10; i++) rd(offs[i], dflt[i]);
    rd(6'h3F, 16'h0);
    idle(3);
    #1;
    chk(outs(), 32'h0000_8000);
  endtask : defaults_check

  // Read data is due in the cycle after each read strobe, else zero;
  // looked at on the falling edge, while the data stands settled
  always @(negedge clock_in) begin
    if (!reset_in && rd_seen) begin
      chk({16'h0, rdata_out}, {16'h0, exp_q.pop_front()});
    end else if (!reset_in) begin
      chk({16'h0, rdata_out}, 32'h0);
    end
    rd_seen = read_in;
  end

  // Watchdog against a hung run
  initial begin
    #50000;
    num_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    reset_in = 1'b1;
    {write_in, read_in, seq_write_in, over_temp_in} = 4'h0;
    {addr_in, seq_addr_in, wdata_in, seq_wdata_in} = 44'h0;
    rnd = $urandom(32'hC385);
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    defaults_check();
    // Set every bit, read back masked; identity read in between
    for (i = 1; i < 10; i++) wr(offs[i], 16'hFFFF);
    wr(6'h3F, 16'hFFFF);
    for (i = 0; i < 10; i++) rd(offs[i], msk[i]);
    rd(6'h3F, 16'h0);
    idle(3);
    #1;
    chk(outs(), 32'h0007_FFFF);
    // Each divider select code reaches the output
    for (i = 0; i < 4; i++) begin
      wr(`PMR_OFF_REF_DIV, 16'(i << 1));
      idle(3);
      #1;
      chk({30'h0, mid_rail_divider_select_out}, 32'(i));
    end
    // Random data, back-to-back write and read
    for (i = 1; i < 10; i++) begin
      rnd = $urandom;
      wr(offs[i], rnd[15:0]);
      rd(offs[i], rnd[15:0] & msk[i]);
    end
    // Over-temperature with shutdown and sensor on
    // Flag moves beside the strobe so no strobe stands two cycles
    wr(`PMR_OFF_POWER, 16'h0197);
    over_temp_in <= 1'b1;
    idle(6);
    chk_pwr(4'b0001);
    rd(`PMR_OFF_POWER, 16'h01D7);
    over_temp_in <= 1'b0;
    idle(6);
    chk_pwr(4'b1111);
    // Sensor off, then shutdown off: outputs stay on
    wr(`PMR_OFF_POWER, 16'h0117);
    over_temp_in <= 1'b1;
    idle(6);
    chk_pwr(4'b1111);
    wr(`PMR_OFF_POWER, 16'h0097);
    idle(6);
    chk_pwr(4'b1111);
    @(posedge clock_in) over_temp_in <= 1'b0;
    // Sequencer port: dropped beside software, taken alone
    op(1'b1, 1'b0, 1'b1, `PMR_OFF_CLOCKS, 16'h0001, 16'h0002);
    rd(`PMR_OFF_CLOCKS, 16'h0001);
    op(1'b0, 1'b0, 1'b1, `PMR_OFF_CLOCKS, 16'h0, 16'h0024);
    rd(`PMR_OFF_CLOCKS, 16'h0024);
    idle(3);
    #1;
    chk(outs() & 32'h0000_0470, 32'h0000_0440);
    // Software reset by any data written to address zero
    rnd = $urandom;
    wr(`PMR_OFF_RESET_ID, rnd[15:0]);
    defaults_check();
    idle(2);
    test_done();
  end
endmodule : pmr_bank_tb
`default_nettype wire
